//--- logic/ebipt_pkg.sv
package ebipt_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int unsigned AXI_ADDR_W      = 8;
	localparam logic [7:0]  OFF_MODE        = 8'h00;
	localparam logic [7:0]  OFF_PERIOD      = 8'h04;
	localparam logic [7:0]  OFF_DUTY        = 8'h08;
	localparam logic [7:0]  OFF_STATUS      = 8'h0C;
	localparam logic [7:0]  RST_MODE        = 8'h00;
	localparam logic [7:0]  RST_PERIOD      = 8'h00;
	localparam logic [7:0]  RST_DUTY        = 8'h00;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// status register field positions
	localparam int unsigned ST_CNT_LSB      = 0;
	localparam int unsigned ST_ACTIVE_BIT   = 8;
	localparam int unsigned ST_DUTYSEL_BIT  = 9;
	localparam int unsigned ST_PEND_BIT     = 10;
	localparam int unsigned ST_RUN_BIT      = 11;

	// ----------------------------------------------------------------
	// counter and count clock
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W           = 8;
	localparam int unsigned PRE_W           = 12;
	localparam int unsigned LOSC_DIV        = 104;
	localparam int unsigned LOSC_PRE_W      = 7;
	localparam int unsigned XFER_MIN_TICKS  = 3;

	typedef enum logic [2:0] {
		CKS_DIV1   = 3'h0,
		CKS_DIV4   = 3'h1,
		CKS_DIV16  = 3'h2,
		CKS_DIV64  = 3'h3,
		CKS_DIV4K  = 3'h4,
		CKS_LOSC   = 3'h5
	} ebipt_cks_t;

	typedef enum logic [1:0] {
		MD_INTERVAL = 2'h0,
		MD_PWM      = 2'h2
	} ebipt_md_t;

	typedef struct packed {
		logic       count_enable_bit;
		logic [2:0] count_clock_select;
		logic [1:0] mode;
		logic       output_level_bit;
		logic       output_enable_bit;
	} ebipt_mode_t;

	typedef struct packed {
		logic             running;
		logic             duty_pending;
		logic             duty_selected;
		logic             active;
		logic [CNT_W-1:0] count;
	} ebipt_status_t;

endpackage

//--- logic/ebipt_prescale.sv
`timescale 1ns/10ps

module ebipt_prescale
	import ebipt_pkg::*;
#(
	parameter int unsigned LOSC_DIVIDE = LOSC_DIV
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       run,
	input  wire logic [2:0] sel,
	output logic            tick
);

	logic [PRE_W-1:0]      div_q;
	logic [15:0]           losc_q;
	logic [LOSC_PRE_W-1:0] lpre_q;
	logic                  losc_tick;
	logic                  hit;

	// ----------------------------------------------------------------
	// dividers, restarted while stopped so the first tick comes early only with CKS_LOSC, whose losc_q runs free
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// low-speed rate stands in for the slow oscillator
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			losc_q <= '0;
		end else if (losc_q == 16'(LOSC_DIVIDE - 1)) begin
			losc_q <= '0;
		end else begin
			losc_q <= losc_q + 1'b1;
		end
	end

	assign losc_tick = (losc_q == 16'(LOSC_DIVIDE - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			lpre_q <= '0;
		end else if (losc_tick) begin
			lpre_q <= lpre_q + 1'b1;
		end
	end

	always_comb begin
		case (ebipt_cks_t'(sel))
			CKS_DIV1:  hit = 1'b1;
			CKS_DIV4:  hit = (div_q[1:0] == 2'h3);
			CKS_DIV16: hit = (div_q[3:0] == 4'hF);
			CKS_DIV64: hit = (div_q[5:0] == 6'h3F);
			CKS_DIV4K: hit = (div_q == 12'hFFF);
			CKS_LOSC:  hit = losc_tick && (lpre_q == 7'h7F);
			default:   hit = 1'b0; // [R20]
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick <= 1'b0;
		end else begin
			tick <= run && hit;
		end
	end

endmodule

//--- logic/ebipt_duty_hold.sv
`timescale 1ns/10ps

module ebipt_duty_hold
	import ebipt_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             running,
	input  wire logic             tick,
	input  wire logic             wr,
	input  wire logic [CNT_W-1:0] wdata,
	input  wire logic             old_match,
	output logic [CNT_W-1:0]      duty_act,
	output logic [CNT_W-1:0]      duty_hold,
	output logic                  pending
);

	logic [1:0] age_q;
	logic       take;

	// transfer only at an old-value match at least three ticks after the write
	assign take = old_match && pending && !wr
		&& (age_q >= 2'(XFER_MIN_TICKS - 1)); // [R12] [R13]

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			duty_hold <= RST_DUTY;
			pending   <= 1'b0;
			age_q     <= '0;
		end else if (wr) begin
			duty_hold <= wdata; // [R11]
			pending   <= running;
			age_q     <= '0;
		end else begin
			if (take) begin
				pending <= 1'b0;
			end
			if (tick && pending && age_q != 2'h3) begin
				age_q <= age_q + 1'b1; // [R13]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			duty_act <= RST_DUTY;
		end else if (wr && !running) begin
			duty_act <= wdata;
		end else if (take) begin
			duty_act <= duty_hold; // [R12]
		end
	end

endmodule

//--- logic/ebipt_timer.sv
// Notes on behaviour
// [R01] counting starts within one count clock
// [R02] interval match raises interrupt, clears counter
// [R03] interval period is compare value plus one
// [R04] each interval match inverts output pin
// [R05] stopping forces interrupt and output inactive
// [R06] software keeps period fixed while PWM runs
// [R07] PWM masks one tick, period compared first
// [R08] PWM period match: clear, interrupt, active, duty
// [R09] PWM duty match: inactive, back to period
// [R10] cycle N+1, active width M+1 ticks
// [R11] running duty writes go to holding latch
// [R12] held duty moves in at old match
// [R13] transfer needs three ticks after the write
// [R14] software rewrites duty when restarting PWM
// [R15] software keeps duty not above period
// [R16] enable clear stops and zeroes the counter
// [R17] waveform reaches pin only with output enable
// [R18] interval mode ignores the duty register
// [R19] level bit sets idle and inactive level
// [R20] count clock select picks rate, rest prohibited
`timescale 1ns/10ps

module ebipt_timer
	import ebipt_pkg::*;
#(
	parameter int unsigned ADDR_W      = AXI_ADDR_W,
	parameter int unsigned LOSC_DIVIDE = LOSC_DIV
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   timer_output_pin,
	output logic                   match_interrupt
);

	typedef enum {
		EBIPT_REG_MODE,
		EBIPT_REG_PERIOD,
		EBIPT_REG_DUTY,
		EBIPT_REG_STATUS,
		EBIPT_REG_NONE
	} ebipt_reg_t;

	// ----------------------------------------------------------------
	// address decode, shared by both bus directions
	// ----------------------------------------------------------------
	function automatic ebipt_reg_t ebipt_decode(input logic [ADDR_W-1:0] addr);
		ebipt_reg_t r;
		r = EBIPT_REG_NONE;
		if (addr == ADDR_W'(OFF_MODE)) begin
			r = EBIPT_REG_MODE;
		end else if (addr == ADDR_W'(OFF_PERIOD)) begin
			r = EBIPT_REG_PERIOD;
		end else if (addr == ADDR_W'(OFF_DUTY)) begin
			r = EBIPT_REG_DUTY;
		end else if (addr == ADDR_W'(OFF_STATUS)) begin
			r = EBIPT_REG_STATUS;
		end
		return r;
	endfunction

	ebipt_mode_t        mode_q;
	logic [CNT_W-1:0]   period_compare_q;
	logic [CNT_W-1:0]   duty_compare;
	logic [CNT_W-1:0]   duty_hold;
	logic               duty_pending;
	logic [ADDR_W-1:0]  waddr_q;
	logic [7:0]         wbyte_q;
	logic               wlane_q;
	logic               wr_fire;
	ebipt_reg_t         wreg;
	ebipt_reg_t         rreg;
	logic               duty_wr;
	logic               tick;
	logic               running;
	logic               is_pwm;
	ebipt_status_t      status;

	logic [CNT_W-1:0]   cnt_q;
	logic [CNT_W-1:0]   cnt_d;
	logic               sel_duty_q;
	logic               sel_duty_d;
	logic               mask_q;
	logic               mask_d;
	logic               active_q;
	logic               active_d;
	logic               irq_d;
	logic               old_match;

	assign running = mode_q.count_enable_bit;
	assign is_pwm  = (ebipt_md_t'(mode_q.mode) == MD_PWM);

	// ----------------------------------------------------------------
	// write channels: address and data taken in either order
	// ----------------------------------------------------------------
	assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wreg    = ebipt_decode(waddr_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			waddr_q       <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			waddr_q       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			wbyte_q      <= '0;
			wlane_q      <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wbyte_q      <= s_axi_wdata[7:0];
			wlane_q      <= s_axi_wstrb[0];
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wreg == EBIPT_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= ebipt_mode_t'(RST_MODE);
		end else if (wr_fire && wlane_q && wreg == EBIPT_REG_MODE) begin
			if (running) begin
				// while counting only the enable bit may change
				mode_q.count_enable_bit <= wbyte_q[7];
			end else begin
				mode_q <= ebipt_mode_t'(wbyte_q);
			end
		end
	end

	// period writes while PWM runs are the caller's fault, not trapped [R06]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			period_compare_q <= RST_PERIOD;
		end else if (wr_fire && wlane_q && wreg == EBIPT_REG_PERIOD) begin
			period_compare_q <= wbyte_q;
		end
	end

	assign duty_wr = wr_fire && wlane_q && (wreg == EBIPT_REG_DUTY);

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	assign rreg = ebipt_decode(s_axi_araddr);

	assign status.running       = running;
	assign status.duty_pending  = duty_pending;
	assign status.duty_selected = sel_duty_q;
	assign status.active        = active_q;
	assign status.count         = cnt_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			case (rreg)
				EBIPT_REG_MODE:   s_axi_rdata <= {24'h000000, mode_q};
				EBIPT_REG_PERIOD: s_axi_rdata <= {24'h000000, period_compare_q};
				EBIPT_REG_DUTY:   s_axi_rdata <= {24'h000000, duty_hold};
				EBIPT_REG_STATUS: s_axi_rdata <= {20'h00000, status};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// count clock and duty holding latch
	// ----------------------------------------------------------------
	ebipt_prescale #(
		.LOSC_DIVIDE (LOSC_DIVIDE)
	) u_prescale (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (running),
		.sel     (mode_q.count_clock_select),
		.tick    (tick)
	);

	// old-value duty match, only seen in PWM duty phase [R18]
	assign old_match = tick && running && is_pwm && !mask_q && sel_duty_q
		&& (cnt_q == duty_compare);

	ebipt_duty_hold u_duty (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.running   (running),
		.tick      (tick),
		.wr        (duty_wr),
		.wdata     (wbyte_q),
		.old_match (old_match),
		.duty_act  (duty_compare),
		.duty_hold (duty_hold),
		.pending   (duty_pending)
	);

	// ----------------------------------------------------------------
	// counter and compare sequencing
	// ----------------------------------------------------------------
	always_comb begin
		cnt_d      = cnt_q;
		sel_duty_d = sel_duty_q;
		mask_d     = mask_q;
		active_d   = active_q;
		irq_d      = 1'b0;
		if (!running) begin
			cnt_d      = '0;     // [R16]
			sel_duty_d = 1'b0;
			mask_d     = 1'b1;
			active_d   = 1'b0;   // [R05]
		end else if (tick) begin
			if (!is_pwm) begin
				mask_d = 1'b0;
				if (cnt_q == period_compare_q) begin
					cnt_d    = '0;             // [R02] [R03]
					irq_d    = 1'b1;           // [R02]
					active_d = !active_q;      // [R04]
				end else begin
					cnt_d = cnt_q + 1'b1;      // [R01]
				end
			end else if (mask_q) begin
				mask_d = 1'b0;                 // [R07]
			end else if (!sel_duty_q) begin
				if (cnt_q == period_compare_q) begin
					cnt_d      = '0;           // [R08] [R10]
					irq_d      = 1'b1;
					active_d   = 1'b1;
					sel_duty_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end else if (cnt_q == duty_compare) begin
				if (cnt_q == period_compare_q) begin
					// duty equal to period: stays active, restarts cycle
					cnt_d = '0;
					irq_d = 1'b1;
				end else begin
					cnt_d      = cnt_q + 1'b1; // [R09] [R10]
					active_d   = 1'b0;
					sel_duty_d = 1'b0;
				end
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q      <= '0;
			sel_duty_q <= 1'b0;
			mask_q     <= 1'b1;
			active_q   <= 1'b0;
		end else begin
			cnt_q      <= cnt_d;
			sel_duty_q <= sel_duty_d;
			mask_q     <= mask_d;
			active_q   <= active_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_interrupt <= 1'b0;
		end else begin
			match_interrupt <= irq_d; // [R05]
		end
	end

	// inactive level is the level bit, active its inverse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_output_pin <= 1'b0;
		end else begin
			timer_output_pin <= mode_q.output_level_bit
				^ (mode_q.output_enable_bit & active_d); // [R17] [R19]
		end
	end

endmodule

//--- tb/ebipt_timer_asserts.sv
`timescale 1ns/10ps

module ebipt_timer_asserts
	import ebipt_pkg::*;
#(
	parameter int unsigned ADDR_W = AXI_ADDR_W
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              timer_output_pin,
	input wire logic              match_interrupt
);
	// ----------------------------------------------------------------
	// bus answers and timer outputs
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wire logic both_taken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

	a_wr_latency: assert property (both_taken
		|=> (!s_axi_awready && !s_axi_bvalid) ##1 s_axi_bvalid)
		else $error("write answer timing wrong");
	a_rd_latency: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer timing wrong");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not freed");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not freed");
	a_reset_quiet: assert property ($rose(aresetn)
		|-> !match_interrupt && !timer_output_pin && !s_axi_bvalid)
		else $error("outputs active after reset");
	a_stop_quiet: assert property (both_taken && s_axi_awaddr == OFF_MODE
		&& s_axi_wstrb[0] && !s_axi_wdata[7] |-> ##4 !match_interrupt)
		else $error("interrupt after stop");
	a_unmapped_err: assert property (both_taken && s_axi_awaddr > OFF_STATUS
		|-> ##2 (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
		else $error("unmapped write not refused");
	a_err_data: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
		|-> s_axi_rdata == 32'h0000_0000)
		else $error("refused read returns data");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0_0000)
		else $error("upper read bits not zero");

	c_irq: cover property (match_interrupt);
	c_pin_rise: cover property ($rose(timer_output_pin));
	c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
endmodule

//--- tb/ebipt_timer_tb_top.sv
`timescale 1ns/10ps

module ebipt_timer_tb_top
	import ebipt_pkg::*;
;
	// ----------------------------------------------------------------
	// stimulus and checks
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [1:0]  br;
		logic [31:0] rv;
		logic [1:0]  rr;
	} ebipt_row_t;
	localparam ebipt_row_t ROWS [4] = '{
		'{OFF_PERIOD, 32'hFFFF_FF5A, RESP_OKAY, 32'h0000_005A, RESP_OKAY},
		'{OFF_DUTY, 32'h0000_00A5, RESP_OKAY, 32'h0000_00A5, RESP_OKAY},
		'{OFF_MODE, 32'h0000_005B, RESP_OKAY, 32'h0000_005B, RESP_OKAY},
		'{8'h10, 32'h0000_0033, RESP_SLVERR, 32'h0000_0000, RESP_SLVERR}};
	localparam int DIV [8] = '{1, 4, 16, 64, 4096, 256, 0, 0};

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rdat, t, hi;
	logic        timer_output_pin, match_interrupt, pa, p1;
	logic [31:0] cyc = 32'h0;
	int          fail_count = 0;
	int          compares = 0;

	ebipt_timer #(.LOSC_DIVIDE(2)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .timer_output_pin(timer_output_pin),
		.match_interrupt(match_interrupt));

	always #20 aclk = ~aclk;

	task automatic give_verdict();
		$display("checks %0d, errors %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 32'h1;
		if (cyc == 32'h15F90) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// handshake outcomes are judged at the falling edge, acted on at the rising one
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b, ta, tw, tb;
		// let an edge pass so bready is never set twice in one step
		@(posedge aclk);
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (b) begin
			@(negedge aclk);
			tb = !aw && !w && s_axi_bvalid;
			ta = aw && s_axi_awready;
			tw = w && s_axi_wready;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
			aw = aw && !ta;
			w = w && !tw;
			b = !tb;
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, ta, tr;
		// let an edge pass so rready is never set twice in one step
		@(posedge aclk);
		ar = 1'b1;
		tr = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!tr) begin
			@(negedge aclk);
			tr = !ar && s_axi_rvalid;
			ta = ar && s_axi_arready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
			ar = ar && !ta;
		end
	endtask

	// counts cycles to the next interrupt and the pin-high cycles on the way
	task automatic wait_irq(input int lim);
		t = 32'h0;
		hi = 32'h0;
		do begin
			@(negedge aclk);
			t++;
			if (timer_output_pin === 1'b1) hi++;
		end while (match_interrupt !== 1'b1 && t < lim);
		pa = timer_output_pin;
		@(posedge aclk);
	endtask

	task automatic stop_chk(input logic [7:0] m);
		wr(OFF_MODE, {24'h0, m}, resp);
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk("pin_stopped", timer_output_pin, m[1]);
		chk("irq_stopped", match_interrupt, 1'b0);
		@(posedge aclk);
		rd(OFF_STATUS, rdat, resp);
		chk("status_stopped", rdat & 32'h0000_09FF, 32'h0);
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("pin_reset", timer_output_pin, 1'b0);
		@(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			rd(8'(4 * i), rdat, resp);
			chk("reset_value", rdat, 32'h0);
		end
		foreach (ROWS[i]) begin
			wr(ROWS[i].a, ROWS[i].d, resp);
			chk("wr_resp", resp, ROWS[i].br);
			rd(ROWS[i].a, rdat, resp);
			chk("rd_data", rdat, ROWS[i].rv);
			chk("rd_resp", resp, ROWS[i].rr);
		end
		wr(OFF_PERIOD, 32'h3, resp);
		wr(OFF_DUTY, 32'h1, resp);
		for (int s = 0; s < 8; s++) begin
			wr(OFF_MODE, {24'h0, 1'b1, 3'(s), 4'h1}, resp);
			wait_irq(DIV[s] != 0 ? 20000 : 300);
			p1 = pa;
			wait_irq(DIV[s] != 0 ? 20000 : 300);
			if (DIV[s] != 0) begin
				chk("interval", t, 32'(4 * DIV[s]));
				chk("toggle", pa, !p1);
				chk("pin_high", hi, p1 ? t - 32'h1 : 32'h1);
			end else
				chk("no_tick", t, 32'h12C);
			stop_chk({1'b0, 3'(s), 4'h1});
		end
		wr(OFF_PERIOD, 32'h7, resp);
		wr(OFF_DUTY, 32'h2, resp);
		wr(OFF_MODE, 32'h89, resp);
		wait_irq(100);
		chk("pwm_first", t, 32'hA);
		chk("pwm_mask", hi, 32'h1);
		chk("pwm_active", pa, 1'b1);
		wait_irq(100);
		chk("pwm_cycle", t, 32'h8);
		chk("pwm_width", hi, 32'h3);
		wr(OFF_DUTY, 32'h5, resp);
		rd(OFF_DUTY, rdat, resp);
		chk("duty_hold", rdat, 32'h5);
		repeat (3) wait_irq(100);
		chk("duty_moved", hi, 32'h6);
		// old-value match falls inside three ticks of this write, so the swap waits a cycle
		wr(OFF_DUTY, 32'h1, resp);
		repeat (2) wait_irq(100);
		chk("duty_late", hi, 32'h6);
		wait_irq(100);
		chk("duty_new", hi, 32'h2);
		stop_chk(8'h09);
		wr(OFF_DUTY, 32'h2, resp);
		wr(OFF_MODE, 32'h8A, resp);
		wait_irq(100);
		wait_irq(100);
		chk("pin_disabled", hi, t);
		chk("cycle_disabled", t, 32'h8);
		stop_chk(8'h0A);
		wr(OFF_MODE, 32'h81, resp);
		wait_irq(100);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("pin_rst", timer_output_pin, 1'b0);
		@(posedge aclk);
		rd(OFF_MODE, rdat, resp);
		chk("mode_rst", rdat, {24'h0, RST_MODE});
		give_verdict();
	end
endmodule

bind ebipt_timer ebipt_timer_asserts #(.ADDR_W(ADDR_W)) u_asserts (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .timer_output_pin(timer_output_pin),
	.match_interrupt(match_interrupt));
